/* hdl/datapath_config_defines.vh */
/*
 * Constants for the metrology datapath configuration register block.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef DATAPATH_CONFIG_DEFINES_VH
`define DATAPATH_CONFIG_DEFINES_VH

// Register map (printed offset is a word index, not a byte address: byte = 4*idx)
`define DPC_CFG_INDEX        12'h060
`define DPC_ADDR_W           14
`define DPC_CFG_RESET        32'h00000000
`define DPC_CFG_WMASK        32'h00003FFB
`define DPC_UNMAPPED_DATA    32'h00000000
`define DPC_RESP_OKAY        2'h0
`define DPC_RESP_SLVERR      2'h2

// Field positions
`define DPC_RPLPF_BIT        13
`define DPC_APLPF_BIT        12
`define DPC_NINT_BIT         11
`define DPC_VNOMC_BIT        10
`define DPC_VNOMB_BIT        9
`define DPC_VNOMA_BIT        8
`define DPC_RMSSRC_BIT       7
`define DPC_ZXSRC_BIT        6
`define DPC_PINT_BIT         5
`define DPC_MULTIPOINT_COMPENSATION_ENABLE_BIT         4
`define DPC_HPF_BIT          3
`define DPC_CURRENT_SUM_HI          1
`define DPC_CURRENT_SUM_LO          0

// Current sum encodings
`define DPC_CURRENT_SUM_PLAIN0      2'h0
`define DPC_CURRENT_SUM_ADDN        2'h1
`define DPC_CURRENT_SUM_SUBN        2'h2
`define DPC_CURRENT_SUM_PLAIN3      2'h3

// Sum operator codes driven out
`define DPC_NOP_NONE         2'h0
`define DPC_NOP_ADD          2'h1
`define DPC_NOP_SUB          2'h2

`endif

/* hdl/metrology_datapath_config.v */
/*
 * Metrology datapath configuration register and its decoded controls.
 * Assumes an Avalon-MM master on clk with a synchronous active-high
 * reset; filters, integrators and sum arithmetic lie outside.
 */
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/100ps
`include "datapath_config_defines.vh"

// Operation
// R01 - Bit 13 set bypasses the total reactive power low-pass filter
// R02 - Bit 12 set bypasses the total active power low-pass filter
// R03 - Bit 11 set enables the neutral current integrator on its own
// R04 - Bits 10, 9, 8 select nominal voltage for phase C, B, A VA
// R05 - Bit 7 set feeds fast rms from raw converter samples
// R06 - Bit 6 picks zero-crossing input before or after conditioning
// R07 - Bit 5 enables the three phase current integrators only
// R08 - Bit 4 enables multipoint gain compensation by current region
// R09 - Bit 3 bypasses every voltage and current high-pass filter
// R10 - Sum field 00 or 11 adds the three phase currents only
// R11 - Sum field 01 adds neutral, 10 subtracts neutral
// R12 - Bit 7 clear feeds fast rms from filtered integrated samples
// R13 - Reserved bits read zero, ignore writes; fields reset to zero

module metrology_datapath_config (
    // Clock and reset
    input  wire                     clk,
    input  wire                     srst,
    // Avalon-MM slave
    input  wire [`DPC_ADDR_W-1:0]   avs_address,
    input  wire                     avs_read,
    input  wire                     avs_write,
    input  wire [31:0]              avs_writedata,
    input  wire [3:0]               avs_byteenable,
    output reg  [31:0]              avs_readdata,
    output reg                      avs_waitrequest,
    output reg  [1:0]               avs_response,
    // Filter controls
    output reg                      reactive_power_lowpass_bypass,
    output reg                      active_power_lowpass_bypass,
    output reg                      highpass_bypass_all,
    // Integrator controls
    output reg                      neutral_integrator_enable,
    output reg                      phase_integrator_enable,
    // Apparent power voltage choice
    output reg                      phase_a_nominal_voltage_use,
    output reg                      phase_b_nominal_voltage_use,
    output reg                      phase_c_nominal_voltage_use,
    // Source selects
    output reg                      fast_rms_source_select,
    output reg                      zero_cross_source_select,
    // Compensation and current sum
    output reg                      multipoint_compensation_enable,
    output reg  [1:0]               current_sum_neutral_op
);

////////////////////////////////////////////////////////////////////////////
// Decode

    localparam ST_IDLE = 1'b0;
    localparam ST_ACK  = 1'b1;

    function [31:0] lane_mask;
        input [3:0] be;
        begin
            lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        end
    endfunction

    function [1:0] sum_op;
        input [1:0] cfg;
        begin
            case (cfg)
                `DPC_CURRENT_SUM_ADDN:  sum_op = `DPC_NOP_ADD;  // see R11
                `DPC_CURRENT_SUM_SUBN:  sum_op = `DPC_NOP_SUB;  // see R11
                default:         sum_op = `DPC_NOP_NONE; // see R10
            endcase
        end
    endfunction

    reg         state_q;
    reg         state_d;
    reg  [31:0] cfg_q;
    reg  [31:0] cfg_d;
    wire        hit;
    wire        req;
    wire [31:0] wmask;

    assign req   = avs_read | avs_write;
    assign hit   = (avs_address[`DPC_ADDR_W-1:2] == `DPC_CFG_INDEX);
    assign wmask = lane_mask(avs_byteenable) & `DPC_CFG_WMASK; // see R13

////////////////////////////////////////////////////////////////////////////
// Bus handshake: one wait cycle, answer on the second

    always @* begin
        state_d = state_q;
        cfg_d   = cfg_q;
        case (state_q)
            ST_IDLE: begin
                if (req) begin
                    state_d = ST_ACK;
                end
            end
            ST_ACK: begin
                state_d = ST_IDLE;
                if (avs_write && hit) begin
                    cfg_d = (cfg_q & ~wmask) | (avs_writedata & wmask);
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk) begin
        if (srst) begin
            state_q         <= ST_IDLE;
            cfg_q           <= `DPC_CFG_RESET; // see R13
            avs_readdata    <= `DPC_UNMAPPED_DATA;
            avs_waitrequest <= 1'b1;
            avs_response    <= `DPC_RESP_OKAY;
        end else begin
            state_q         <= state_d;
            cfg_q           <= cfg_d;
            avs_waitrequest <= ~(state_q == ST_IDLE && req);
            if (state_q == ST_IDLE && req && avs_read && hit) begin
                avs_readdata <= cfg_q & `DPC_CFG_WMASK; // see R13
            end else begin
                avs_readdata <= `DPC_UNMAPPED_DATA;
            end
            if (state_q == ST_IDLE && req && !hit) begin
                avs_response <= `DPC_RESP_SLVERR;
            end else begin
                avs_response <= `DPC_RESP_OKAY;
            end
        end
    end

////////////////////////////////////////////////////////////////////////////
// Control outputs, registered from the configuration

    always @(posedge clk) begin
        if (srst) begin
            reactive_power_lowpass_bypass  <= 1'b0;
            active_power_lowpass_bypass    <= 1'b0;
            highpass_bypass_all            <= 1'b0;
            neutral_integrator_enable      <= 1'b0;
            phase_integrator_enable        <= 1'b0;
            phase_a_nominal_voltage_use    <= 1'b0;
            phase_b_nominal_voltage_use    <= 1'b0;
            phase_c_nominal_voltage_use    <= 1'b0;
            fast_rms_source_select         <= 1'b0;
            zero_cross_source_select       <= 1'b0;
            multipoint_compensation_enable <= 1'b0;
            current_sum_neutral_op         <= `DPC_NOP_NONE;
        end else begin
            reactive_power_lowpass_bypass  <= cfg_q[`DPC_RPLPF_BIT]; // see R01
            active_power_lowpass_bypass    <= cfg_q[`DPC_APLPF_BIT]; // see R02
            highpass_bypass_all            <= cfg_q[`DPC_HPF_BIT];   // see R09
            neutral_integrator_enable      <= cfg_q[`DPC_NINT_BIT];  // see R03
            phase_integrator_enable        <= cfg_q[`DPC_PINT_BIT];  // see R07
            phase_a_nominal_voltage_use    <= cfg_q[`DPC_VNOMA_BIT]; // see R04
            phase_b_nominal_voltage_use    <= cfg_q[`DPC_VNOMB_BIT]; // see R04
            phase_c_nominal_voltage_use    <= cfg_q[`DPC_VNOMC_BIT]; // see R04
            fast_rms_source_select  <= cfg_q[`DPC_RMSSRC_BIT]; // see R05 R12
            zero_cross_source_select       <= cfg_q[`DPC_ZXSRC_BIT]; // see R06
            multipoint_compensation_enable <= cfg_q[`DPC_MULTIPOINT_COMPENSATION_ENABLE_BIT];  // see R08
            current_sum_neutral_op <=
                sum_op(cfg_q[`DPC_CURRENT_SUM_HI:`DPC_CURRENT_SUM_LO]); // see R10 R11
        end
    end

endmodule // metrology_datapath_config

/* tb/dpc_props.sv */
/* Assertions on the configuration block ports.
   Assumes a bind onto every metrology_datapath_config. */
`timescale 1ns/100ps
`include "datapath_config_defines.vh"
module dpc_props (
    // Clock, reset and bus
    input logic        clk, srst, avs_write, avs_read, avs_waitrequest,
    input logic [13:0] avs_address,
    input logic [31:0] avs_writedata, avs_readdata,
    input logic [3:0]  avs_byteenable,
    // Controls
    input logic [1:0]  current_sum_neutral_op,
    input logic reactive_power_lowpass_bypass, active_power_lowpass_bypass,
        neutral_integrator_enable, phase_a_nominal_voltage_use,
        phase_b_nominal_voltage_use, phase_c_nominal_voltage_use,
        fast_rms_source_select, highpass_bypass_all,
        zero_cross_source_select, phase_integrator_enable,
        multipoint_compensation_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence wr_s;
        avs_write && !avs_waitrequest && avs_byteenable == 4'hF &&
        avs_address[13:2] == `DPC_CFG_INDEX;
    endsequence
    property follows(s, b);
        wr_s |-> ##2 s == $past(avs_writedata[b], 2);
    endproperty
    rplpf_follow_a:
        assert property (follows(reactive_power_lowpass_bypass, 13))
        else $error("bit 13 output wrong");
    aplpf_follow_a:
        assert property (follows(active_power_lowpass_bypass, 12))
        else $error("bit 12 output wrong");
    nint_follow_a:
        assert property (follows(neutral_integrator_enable, 11))
        else $error("bit 11 output wrong");
    rms_src_a:
        assert property (follows(fast_rms_source_select, 7))
        else $error("bit 7 output wrong");
    zx_src_a:
        assert property (follows(zero_cross_source_select, 6))
        else $error("bit 6 output wrong");
    pint_follow_a:
        assert property (follows(phase_integrator_enable, 5))
        else $error("bit 5 output wrong");
    multipoint_compensation_enable_follow_a:
        assert property (follows(multipoint_compensation_enable, 4))
        else $error("bit 4 output wrong");
    hpf_bypass_a:
        assert property (follows(highpass_bypass_all, 3))
        else $error("bit 3 output wrong");
    nominal_voltage_rms_follow_a:
        assert property (wr_s |-> ##2 {phase_c_nominal_voltage_use,
            phase_b_nominal_voltage_use, phase_a_nominal_voltage_use}
            == $past(avs_writedata[10:8], 2)) else $error("nominal use");
    sum_op_a:
        assert property (wr_s |-> ##2 current_sum_neutral_op ==
            (^$past(avs_writedata[1:0], 2) ?
            $past(avs_writedata[1:0], 2) : 2'h0)) else $error("sum op");
    resv_zero_a:
        assert property (avs_read && !avs_waitrequest |->
            (avs_readdata & ~32'h00003FFB) == 32'h0) else $error("reserved");
endmodule // dpc_props
bind metrology_datapath_config dpc_props i_props (.*);

/* tb/metrology_datapath_config_test.sv */
/* Testbench for the configuration block.
   Assumes the Avalon register at byte address 0x180. */
`timescale 1ns/100ps
module metrology_datapath_config_test;
    logic        clk = 0, srst = 1, avs_read = 0, avs_write = 0;
    logic [13:0] avs_address = 14'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [3:0]  avs_byteenable = 4'hF;
    logic        avs_waitrequest;
    logic [1:0]  avs_response, current_sum_neutral_op, r;
    logic reactive_power_lowpass_bypass, active_power_lowpass_bypass,
        neutral_integrator_enable, phase_c_nominal_voltage_use,
        phase_b_nominal_voltage_use, phase_a_nominal_voltage_use,
        fast_rms_source_select, zero_cross_source_select,
        phase_integrator_enable, multipoint_compensation_enable,
        highpass_bypass_all;
    wire [10:0] ctl = {reactive_power_lowpass_bypass,
        active_power_lowpass_bypass, neutral_integrator_enable,
        phase_c_nominal_voltage_use, phase_b_nominal_voltage_use,
        phase_a_nominal_voltage_use, fast_rms_source_select,
        zero_cross_source_select, phase_integrator_enable,
        multipoint_compensation_enable, highpass_bypass_all};
    int n_mismatch = 0, comparisons = 0;
    metrology_datapath_config i_dut (.*);
    initial forever #20 clk = ~clk;
    task chk(input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [13:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n == 20) chk(32'h0, 32'h1);
        q = avs_readdata;
        r = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task t_bits;
        for (int i = 3; i < 14; i++) begin
            bus(1, 14'h0180, 32'h1 << i);
            repeat (2) @(posedge clk);
            chk(ctl,1<<i-3);
        end
    endtask
    task t_sum;
        for (int c = 0; c < 4; c++) begin
            bus(1, 14'h0180, c);
            repeat (2) @(posedge clk);
            chk(current_sum_neutral_op, c % 3 ? c : 0);
        end
    endtask
    task t_resv;
        bus(1, 14'h0180, 32'hFFFFFFFF);
        bus(0, 14'h0180, 32'h0);
        chk(q, 32'h00003FFB);
        chk(ctl, 32'h000007FF);
        bus(1, 14'h0000, 32'h0);
        bus(0, 14'h0000, 32'h0);
        chk(r, 32'h2);
        avs_byteenable <= 4'h1;
        bus(1, 14'h0180, 32'h0);
        avs_byteenable <= 4'hF;
        bus(0, 14'h0180, 32'h0);
        chk(q, 32'h00003F00);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        bus(0, 14'h0180, 32'h0);
        chk(q, 32'h0);
        chk(ctl, 32'h0);
    endtask
    task wrap_up;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        bus(0, 14'h0180, 32'h0);
        chk(q | ctl, 32'h0);
        t_bits;
        t_sum;
        t_resv;
        wrap_up;
    end
    initial begin
        #20000;
        n_mismatch++;
        wrap_up;
    end
endmodule // metrology_datapath_config_test
